// ===== hdl/rto_pkg.sv
// Purpose: Constants for the reload timer with one-shot control.
// Assumes: 8-bit registers at byte addresses on a plain strobe port.
// Notes: Tags below mark the logic that carries each behaviour.
// How it works
// - Writing one to the trigger bit fires a one-shot; bit reads zero.
// - Writing one to the halt bit stops one-shot counting; reads zero.
// - Active flag reads one while a one-shot runs, wait period included.
// - Forced stop clears the one-shot active flag.
// - One-shot control acts only in one-shot or delayed one-shot mode.
// - Mode field: timer, waveform, one-shot, delayed one-shot.
// - Write control zero loads reload and counter; one loads reload only.
// - Source field: clock, clock/8, companion underflow, clock/2.
// - Cutoff bit one removes the count source from the counter.
// - Eight-bit prescaler counts the source, reload 00h to FFh.
// - Forced stop loads FFh into the prescaler.
// - Write-only secondary counts in waveform and delayed one-shot modes.
// - In waveform and delayed one-shot modes the counter reloads alternately from primary and secondary.
// - Primary read returns the live count, also in the secondary period.
// - Secondary resets to all ones; forced stop loads FFh too.
// - Output control holds level, switch, trigger enable and polarity.
// - Forced stop returns reloads, start and status flags to reset.
// - In one-shot modes the count status shows an accepted trigger.
package rto_pkg;
    localparam logic [15:0] RTO_CC_ADR = 16'h0108;
    localparam logic [15:0] RTO_OS_ADR = 16'h0109;
    localparam logic [15:0] RTO_IOC_ADR = 16'h010a;
    localparam logic [15:0] RTO_MD_ADR = 16'h010b;
    localparam logic [15:0] RTO_PRE_ADR = 16'h010c;
    localparam logic [15:0] RTO_SEC_ADR = 16'h010d;
    localparam logic [15:0] RTO_PRI_ADR = 16'h010e;
    localparam int RTO_CC_START = 0;
    localparam int RTO_CC_STATUS = 1;
    localparam int RTO_CC_FSTOP = 2;
    localparam int RTO_OS_TRIG = 0;
    localparam int RTO_OS_HALT = 1;
    localparam int RTO_OS_ACTIVE = 2;
    localparam int RTO_IO_LVL = 0;
    localparam int RTO_IO_SW = 1;
    localparam int RTO_IO_TRGEN = 2;
    localparam int RTO_IO_TRGPOL = 3;
    localparam int RTO_MD_WC = 3;
    localparam int RTO_MD_CUT = 7;
    localparam logic [7:0] RTO_IOC_MASK = 8'h0f;
    localparam logic [7:0] RTO_MD_MASK = 8'hbb;
    localparam logic [7:0] RTO_ZERO = 8'h00;
    localparam logic [7:0] RTO_ONES = 8'hff;
    localparam logic [2:0] RTO_DIV8_LAST = 3'h7;
    typedef enum logic [1:0] {
        RTO_MD_TIMER = 2'h0,
        RTO_MD_WAVE = 2'h1,
        RTO_MD_ONESHOT = 2'h2,
        RTO_MD_DELAYED = 2'h3
    } rto_mode_t;
    typedef enum logic [1:0] {
        RTO_SRC_DIV1 = 2'h0,
        RTO_SRC_DIV8 = 2'h1,
        RTO_SRC_COMP = 2'h2,
        RTO_SRC_DIV2 = 2'h3
    } rto_src_t;
    typedef enum logic [1:0] {
        RTO_PH_IDLE = 2'h0,
        RTO_PH_PRI = 2'h1,
        RTO_PH_SEC = 2'h3
    } rto_phase_t;
endpackage : rto_pkg

// ===== hdl/rto_timer.sv
// Purpose: Eight-bit reload timer with prescaler and one-shot control.
// Assumes: Inputs synchronous to clk; one strobe per cycle at most.
// Notes: Read data appear in the cycle after the read strobe.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module rto_timer
    import rto_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic comp_underflow,
    input wire logic trig_in,
    output logic pulse_out,
    output logic underflow_pulse
);

    logic start_r;
    logic cstf_r;
    logic [7:0] ioc_r;
    logic [7:0] mode_r;
    logic [7:0] pre_rld_r;
    logic [7:0] pre_cnt_r;
    logic [7:0] sec_buf_r;
    logic [7:0] sec_rld_r;
    logic [7:0] pri_rld_r;
    logic [7:0] cnt_r;
    logic [7:0] rd_data_r;
    logic [2:0] div_r;
    logic trig_prev_r;
    logic pulse_r;
    logic uf_r;
    rto_phase_t ph_r;

    logic wr_cc;
    logic wr_os;
    logic wr_ioc;
    logic wr_md;
    logic wr_pre;
    logic wr_sec;
    logic wr_pri;
    logic fstop;
    logic osm;
    logic wc;
    logic cut;
    rto_mode_t mode;
    rto_src_t src;
    logic src_tick;
    logic tick;
    logic run;
    logic puf;
    logic cuf;
    logic pin_trig;
    logic sw_trig;
    logic halt;
    logic trig_acc;
    logic os_active;
    logic act;

    assign wr_cc = wr_en && (addr == RTO_CC_ADR);
    assign wr_os = wr_en && (addr == RTO_OS_ADR);
    assign wr_ioc = wr_en && (addr == RTO_IOC_ADR);
    assign wr_md = wr_en && (addr == RTO_MD_ADR);
    assign wr_pre = wr_en && (addr == RTO_PRE_ADR);
    assign wr_sec = wr_en && (addr == RTO_SEC_ADR);
    assign wr_pri = wr_en && (addr == RTO_PRI_ADR);
    assign fstop = wr_cc && wr_data[RTO_CC_FSTOP];

    assign mode = rto_mode_t'(mode_r[1:0]);
    assign src = rto_src_t'(mode_r[5:4]);
    assign wc = mode_r[RTO_MD_WC];
    assign cut = mode_r[RTO_MD_CUT];
    assign osm = mode_r[1];

    // Software registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_r <= 1'b0;
            ioc_r <= RTO_ZERO;
            mode_r <= RTO_ZERO;
            pre_rld_r <= RTO_ONES;
            sec_buf_r <= RTO_ONES;
            sec_rld_r <= RTO_ONES;
            pri_rld_r <= RTO_ONES;
        end else if (ce) begin
            if (fstop) begin
                start_r <= 1'b0;
                pre_rld_r <= RTO_ONES;
                sec_buf_r <= RTO_ONES;
                sec_rld_r <= RTO_ONES;
                pri_rld_r <= RTO_ONES;
            end else begin
                if (wr_cc) begin
                    start_r <= wr_data[RTO_CC_START];
                end
                if (wr_pre) begin
                    pre_rld_r <= wr_data;
                end
                if (wr_sec) begin
                    sec_buf_r <= wr_data;
                end
                // Secondary only takes hold with the primary write
                if (wr_pri) begin
                    pri_rld_r <= wr_data;
                    sec_rld_r <= sec_buf_r;
                end
            end
            if (wr_ioc) begin
                ioc_r <= wr_data & RTO_IOC_MASK;
            end
            if (wr_md) begin
                mode_r <= wr_data & RTO_MD_MASK;
            end
        end
    end

    // Count source; the divider runs free so f/2 and f/8 keep phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_r <= 3'h0;
        end else if (ce) begin
            div_r <= div_r + 3'h1;
        end
    end

    always_comb begin
        case (src)
            RTO_SRC_DIV1: src_tick = 1'b1;
            RTO_SRC_DIV8: src_tick = (div_r == RTO_DIV8_LAST);
            RTO_SRC_COMP: src_tick = comp_underflow;
            RTO_SRC_DIV2: src_tick = div_r[0];
            default: src_tick = 1'b0;
        endcase
    end

    assign tick = src_tick && !cut;
    assign run = start_r && (ph_r != RTO_PH_IDLE) && tick;
    assign puf = run && (pre_cnt_r == RTO_ZERO);
    assign cuf = puf && (cnt_r == RTO_ZERO);

    // One-shot trigger sources
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_prev_r <= 1'b0;
        end else if (ce) begin
            trig_prev_r <= trig_in;
        end
    end

    assign pin_trig = ioc_r[RTO_IO_TRGEN] && (ioc_r[RTO_IO_TRGPOL] ?
        (trig_in && !trig_prev_r) : (!trig_in && trig_prev_r));
    assign sw_trig = wr_os && wr_data[RTO_OS_TRIG] && osm;
    assign halt = wr_os && wr_data[RTO_OS_HALT] && osm;
    // Halt in the same write, or a forced stop, beats the trigger
    assign trig_acc = osm && start_r && (ph_r == RTO_PH_IDLE) &&
        (sw_trig || pin_trig) && !halt && !fstop;
    assign os_active = osm && (ph_r != RTO_PH_IDLE);

    // Prescaler counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_cnt_r <= RTO_ONES;
        end else if (ce) begin
            if (fstop) begin
                pre_cnt_r <= RTO_ONES;
            end else if (wr_pre) begin
                pre_cnt_r <= wr_data;
            end else if (halt || puf) begin
                pre_cnt_r <= pre_rld_r;
            end else if (run) begin
                pre_cnt_r <= pre_cnt_r - 8'h01;
            end
        end
    end

    // Main counter and reload phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= RTO_ONES;
            ph_r <= RTO_PH_IDLE;
        end else if (ce) begin
            if (fstop) begin
                cnt_r <= RTO_ONES;
                ph_r <= RTO_PH_IDLE;
            end else begin
                if (halt) begin
                    ph_r <= RTO_PH_IDLE;
                    cnt_r <= pri_rld_r;
                end else if (trig_acc) begin
                    ph_r <= RTO_PH_PRI;
                end else if (!osm && !start_r) begin
                    ph_r <= RTO_PH_IDLE;
                end else if (!osm && (ph_r == RTO_PH_IDLE)) begin
                    ph_r <= RTO_PH_PRI;
                end else if (cuf) begin
                    case (mode)
                        RTO_MD_TIMER: begin
                            cnt_r <= pri_rld_r;
                        end
                        RTO_MD_WAVE: begin
                            if (ph_r == RTO_PH_PRI) begin
                                ph_r <= RTO_PH_SEC;
                                cnt_r <= sec_rld_r;
                            end else begin
                                ph_r <= RTO_PH_PRI;
                                cnt_r <= pri_rld_r;
                            end
                        end
                        RTO_MD_ONESHOT: begin
                            ph_r <= RTO_PH_IDLE;
                            cnt_r <= pri_rld_r;
                        end
                        RTO_MD_DELAYED: begin
                            if (ph_r == RTO_PH_PRI) begin
                                ph_r <= RTO_PH_SEC;
                                cnt_r <= sec_rld_r;
                            end else begin
                                ph_r <= RTO_PH_IDLE;
                                cnt_r <= pri_rld_r;
                            end
                        end
                        default: begin
                            ph_r <= RTO_PH_IDLE;
                        end
                    endcase
                end else if (puf) begin
                    cnt_r <= cnt_r - 8'h01;
                end
                // Reload modes rely on software keeping this bit at one
                if (wr_pri && !wc) begin
                    cnt_r <= wr_data;
                end
            end
        end
    end

    // Count status follows start; in one-shot modes an accepted trigger
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cstf_r <= 1'b0;
        end else if (ce) begin
            if (fstop) begin
                cstf_r <= 1'b0;
            end else begin
                cstf_r <= start_r && (!osm || trig_acc ||
                    (ph_r != RTO_PH_IDLE));
            end
        end
    end

    always_comb begin
        case (mode)
            RTO_MD_WAVE: act = (ph_r == RTO_PH_PRI);
            RTO_MD_ONESHOT: act = (ph_r == RTO_PH_PRI);
            RTO_MD_DELAYED: act = (ph_r == RTO_PH_SEC);
            default: act = 1'b0;
        endcase
    end

    // Output pin and underflow event
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulse_r <= 1'b1;
            uf_r <= 1'b0;
        end else if (ce) begin
            pulse_r <= (act && !ioc_r[RTO_IO_SW]) ~^ ioc_r[RTO_IO_LVL];
            uf_r <= cuf;
        end
    end

    // Read port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_r <= RTO_ZERO;
        end else if (ce) begin
            if (rd_en) begin
                case (addr)
                    RTO_CC_ADR: rd_data_r <= {5'h00, 1'b0, cstf_r, start_r};
                    RTO_OS_ADR: rd_data_r <= {5'h00, os_active, 2'h0};
                    RTO_IOC_ADR: rd_data_r <= ioc_r;
                    RTO_MD_ADR: rd_data_r <= mode_r;
                    RTO_PRE_ADR: rd_data_r <= pre_cnt_r;
                    RTO_PRI_ADR: rd_data_r <= cnt_r;
                    default: rd_data_r <= RTO_ZERO;
                endcase
            end else begin
                rd_data_r <= RTO_ZERO;
            end
        end
    end

    assign rd_data = rd_data_r;
    assign pulse_out = pulse_r;
    assign underflow_pulse = uf_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    trig_rd_zero_a: assert property (
        rd_en && addr == RTO_OS_ADR |=> !rd_data[RTO_OS_TRIG])
        else $error("Trigger bit read back as one");
    halt_rd_zero_a: assert property (
        rd_en && addr == RTO_OS_ADR |=> !rd_data[RTO_OS_HALT])
        else $error("Halt bit read back as one");
    active_rd_a: assert property (
        rd_en && addr == RTO_OS_ADR
        |=> rd_data[RTO_OS_ACTIVE] == $past(os_active))
        else $error("Active flag read differs from one-shot state");
    fstop_clear_a: assert property (
        fstop |=> !os_active && !cstf_r && !start_r)
        else $error("Forced stop left a status flag set");
    mode_gate_a: assert property (
        wr_os && !osm && mode_r[0] == 1'b0 && start_r &&
        ph_r == RTO_PH_PRI |=> ph_r == RTO_PH_PRI)
        else $error("One-shot control acted in timer mode");
    trig_start_a: assert property (
        trig_acc |=> ph_r == RTO_PH_PRI && cstf_r)
        else $error("Accepted trigger did not start the one-shot");
    load_cnt_a: assert property (
        wr_pri && !wc |=> cnt_r == $past(wr_data))
        else $error("Counter not loaded by primary write");
    // Only a register write may move the counters while cut off
    cutoff_tick_a: assert property (
        cut && !wr_en |=> $stable(pre_cnt_r) && $stable(cnt_r))
        else $error("Counters moved while the source was cut off");
    fstop_ones_a: assert property (
        fstop |=> pre_cnt_r == RTO_ONES && pre_rld_r == RTO_ONES &&
        sec_rld_r == RTO_ONES && pri_rld_r == RTO_ONES)
        else $error("Forced stop did not load all ones");
    pri_read_a: assert property (
        rd_en && addr == RTO_PRI_ADR |=> rd_data == $past(cnt_r))
        else $error("Primary read did not return the count");
    alt_reload_a: assert property (
        cuf && mode == RTO_MD_WAVE && ph_r == RTO_PH_PRI &&
        !(wr_pri && !wc) && !wr_os && !fstop
        |=> ph_r == RTO_PH_SEC && cnt_r == $past(sec_rld_r))
        else $error("Waveform did not switch to secondary reload");
    sec_wo_a: assert property (
        rd_en && addr == RTO_SEC_ADR |=> rd_data == RTO_ZERO)
        else $error("Secondary register was readable");
    uf_event_a: assert property (
        cuf |=> underflow_pulse)
        else $error("Counter underflow gave no event pulse");
    halt_stop_a: assert property (
        halt |=> !os_active)
        else $error("Halt left the one-shot running");
    pre_load_a: assert property (
        wr_pre |=> pre_cnt_r == $past(wr_data) &&
        pre_rld_r == $past(wr_data))
        else $error("Prescaler write did not load counter and reload");
    cstf_stop_a: assert property (
        !start_r |=> !cstf_r)
        else $error("Count status set while count start was clear");
    oneshot_end_a: assert property (
        cuf && mode == RTO_MD_ONESHOT && !fstop |=> !os_active)
        else $error("One-shot still active after its width expired");
    wave_back_a: assert property (
        cuf && mode == RTO_MD_WAVE && ph_r == RTO_PH_SEC &&
        !(wr_pri && !wc) && !fstop
        |=> ph_r == RTO_PH_PRI && cnt_r == $past(pri_rld_r))
        else $error("Waveform did not return to primary reload");

    oneshot_done_c: cover property (
        mode == RTO_MD_ONESHOT && cuf ##1 ph_r == RTO_PH_IDLE);
    delayed_width_c: cover property (
        mode == RTO_MD_DELAYED && ph_r == RTO_PH_SEC && cuf);
    wave_cycle_c: cover property (
        mode == RTO_MD_WAVE && ph_r == RTO_PH_SEC && cuf);
    fstop_run_c: cover property (fstop && os_active);
    pin_trig_c: cover property (trig_acc && pin_trig);

endmodule : rto_timer

// ===== verif/test_rto_timer.sv
// Purpose: Self-checking bench for the reload timer register block.
// Assumes: ce high but for one freeze; one strobe per task, one idle after.
// Notes: Rates are checked as count differences over fixed gaps.
`timescale 1ns/1ps
module test_rto_timer;
    import rto_pkg::*;
    logic clk, rst_n, ce, wr_en, rd_en, comp_underflow, trig_in;
    logic [15:0] addr;
    logic [7:0] wr_data, rd_data, v1, v2;
    logic pulse_out, underflow_pulse, lvl;
    int error_cnt = 0;
    int check_count = 0;
    int seed = 98;
    int n;
    int nu;
    logic [7:0] d;

    `define CHK(g_v, e_v) begin check_count++; \
        if ((g_v) !== (e_v)) begin error_cnt++; \
        $display("[ERR] %0t got %h exp %h", $time, g_v, e_v); end end

    rto_timer rto_timer_i (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .comp_underflow(comp_underflow), .trig_in(trig_in),
        .pulse_out(pulse_out), .underflow_pulse(underflow_pulse));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Counts expected over an eight-cycle gap for each clock source
    function automatic logic [7:0] exp_step(input logic [1:0] src);
        case (src)
            2'h0: exp_step = 8'h08;
            2'h1: exp_step = 8'h01;
            default: exp_step = 8'h04;
        endcase
    endfunction : exp_step

    function automatic int run_cycles(input int pre, input int cnt);
        run_cycles = (pre + 1) * (cnt + 1);
    endfunction : run_cycles

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : wr

    // Data sampled at the edge after the read, before it drops back to 0
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        v = rd_data;
    endtask : rd

    // Also counts underflow events seen during the run
    task automatic next_run(output logic l, output int k, output int u);
        l = pulse_out;
        k = 0;
        u = 0;
        while (pulse_out === l && k < 600) begin
            @(posedge clk);
            k++;
            if (underflow_pulse === 1'b1) begin
                u++;
            end
        end
    endtask : next_run

    task automatic tally_and_finish;
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0; ce = 1'b1; wr_en = 1'b0; rd_en = 1'b0;
        addr = 16'h0000; wr_data = 8'h00; comp_underflow = 1'b0;
        trig_in = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK(pulse_out, 1'b1)
        `CHK(underflow_pulse, 1'b0)
        rd(RTO_CC_ADR, d); `CHK(d, 8'h00)
        rd(RTO_OS_ADR, d); `CHK(d, 8'h00)
        rd(RTO_IOC_ADR, d); `CHK(d, 8'h00)
        rd(RTO_MD_ADR, d); `CHK(d, 8'h00)
        rd(RTO_PRE_ADR, d); `CHK(d, 8'hff)
        rd(RTO_SEC_ADR, d); `CHK(d, 8'h00)
        rd(RTO_PRI_ADR, d); `CHK(d, 8'hff)
        // Random field values while stopped, unmapped place included
        repeat (6) begin
            v1 = 8'($random(seed));
            wr(RTO_IOC_ADR, v1);
            rd(RTO_IOC_ADR, d); `CHK(d, v1 & 8'h0f)
            wr(RTO_MD_ADR, v1);
            rd(RTO_MD_ADR, d); `CHK(d, v1 & 8'hbb)
            wr(16'h010f, v1);
            rd(16'h010f, d); `CHK(d, 8'h00)
            wr(RTO_SEC_ADR, v1);
            rd(RTO_SEC_ADR, d); `CHK(d, 8'h00)
        end
        wr(RTO_IOC_ADR, 8'h00);
        wr(RTO_PRE_ADR, 8'h00);
        // Each clock source over an eight-cycle gap; companion underflow over five pulses
        for (int s = 0; s < 4; s++) begin
            wr(RTO_CC_ADR, 8'h00);
            wr(RTO_MD_ADR, {2'b00, 2'(s), 4'h0});
            wr(RTO_PRI_ADR, 8'hff);
            wr(RTO_CC_ADR, 8'h01);
            repeat (3) @(posedge clk);
            rd(RTO_PRI_ADR, v1);
            if (s == 2) begin
                repeat (5) begin
                    comp_underflow <= 1'b1;
                    @(posedge clk);
                    comp_underflow <= 1'b0;
                    @(posedge clk);
                end
                rd(RTO_PRI_ADR, v2); `CHK(8'(v1 - v2), 8'h05)
            end else begin
                repeat (6) @(posedge clk);
                rd(RTO_PRI_ADR, v2);
                `CHK(8'(v1 - v2), exp_step(2'(s)))
            end
        end
        // Clock enable low freezes counter and divider alike
        rd(RTO_PRI_ADR, v1);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        rd(RTO_PRI_ADR, v2); `CHK(8'(v1 - v2), 8'h02)
        // Cutoff holds the count still
        wr(RTO_CC_ADR, 8'h00);
        wr(RTO_MD_ADR, 8'h80);
        wr(RTO_CC_ADR, 8'h01);
        rd(RTO_PRI_ADR, v1);
        repeat (6) @(posedge clk);
        rd(RTO_PRI_ADR, v2); `CHK(v2, v1)
        // Forced stop returns count control, prescaler and counter to reset values
        wr(RTO_PRE_ADR, 8'h12);
        wr(RTO_SEC_ADR, 8'h34);
        wr(RTO_CC_ADR, 8'h04);
        rd(RTO_CC_ADR, d); `CHK(d, 8'h00)
        rd(RTO_PRE_ADR, d); `CHK(d, 8'hff)
        rd(RTO_PRI_ADR, d); `CHK(d, 8'hff)
        // Write control selects whether the counter follows
        wr(RTO_MD_ADR, 8'h08);
        wr(RTO_PRI_ADR, 8'h33);
        rd(RTO_PRI_ADR, d); `CHK(d, 8'hff)
        wr(RTO_MD_ADR, 8'h00);
        wr(RTO_PRI_ADR, 8'h44);
        rd(RTO_PRI_ADR, d); `CHK(d, 8'h44)
        // Trigger ignored outside the one-shot modes
        for (int m = 0; m < 2; m++) begin
            wr(RTO_CC_ADR, 8'h04);
            wr(RTO_MD_ADR, {6'h02, 2'(m)});
            wr(RTO_CC_ADR, 8'h01);
            wr(RTO_OS_ADR, 8'h03);
            rd(RTO_OS_ADR, d); `CHK(d, 8'h00)
        end
        // One-shot and delayed one-shot: trigger, halt, forced stop
        for (int m = 2; m < 4; m++) begin
            wr(RTO_CC_ADR, 8'h04);
            wr(RTO_MD_ADR, 8'h00);
            wr(RTO_PRE_ADR, 8'h00);
            wr(RTO_PRI_ADR, 8'h80);
            wr(RTO_MD_ADR, {6'h02, 2'(m)});
            wr(RTO_CC_ADR, 8'h01);
            wr(RTO_OS_ADR, 8'h01);
            rd(RTO_OS_ADR, d); `CHK(d, 8'h04)
            rd(RTO_CC_ADR, d); `CHK(d, 8'h03)
            wr(RTO_OS_ADR, 8'h02);
            rd(RTO_OS_ADR, d); `CHK(d, 8'h00)
            wr(RTO_OS_ADR, 8'h01);
            rd(RTO_OS_ADR, d); `CHK(d, 8'h04)
            wr(RTO_CC_ADR, 8'h04);
            rd(RTO_OS_ADR, d); `CHK(d, 8'h00)
        end
        // Pin trigger on a rising edge; a short width lets the shot end
        wr(RTO_MD_ADR, 8'h00);
        wr(RTO_PRE_ADR, 8'h00);
        wr(RTO_PRI_ADR, 8'h03);
        wr(RTO_MD_ADR, 8'h0a);
        wr(RTO_IOC_ADR, 8'h0c);
        wr(RTO_CC_ADR, 8'h01);
        trig_in <= 1'b1;
        repeat (3) @(posedge clk);
        rd(RTO_OS_ADR, d); `CHK(d, 8'h04)
        rd(RTO_OS_ADR, d); `CHK(d, 8'h00)
        trig_in <= 1'b0;
        // Waveform: primary and secondary periods alternate on the pin
        wr(RTO_CC_ADR, 8'h04);
        wr(RTO_IOC_ADR, 8'h00);
        wr(RTO_MD_ADR, 8'h00);
        wr(RTO_PRE_ADR, 8'h00);
        wr(RTO_PRI_ADR, 8'h03);
        wr(RTO_MD_ADR, 8'h09);
        wr(RTO_SEC_ADR, 8'h05);
        wr(RTO_PRI_ADR, 8'h03);
        wr(RTO_CC_ADR, 8'h01);
        next_run(lvl, n, nu);
        next_run(lvl, n, nu);
        repeat (2) begin
            next_run(lvl, n, nu);
            `CHK(n, lvl ? run_cycles(0, 5) : run_cycles(0, 3))
            `CHK(nu, 1)
        end
        tally_and_finish();
    end
endmodule : test_rto_timer
